// ==== hw/touch_block_pkg.sv ====
// Constants, field layouts and decode helpers for touch blocking and pattern
package touch_block_pkg;

  localparam int NUM_INPUTS = 3;
  localparam int DATA_W     = 8;

  // Register offsets
  localparam logic [7:0] TOUCH_LIMIT_CONFIG_ADDR    = 8'h2a;
  localparam logic [7:0] PATTERN_DETECT_CONFIG_ADDR = 8'h2b;
  localparam logic [7:0] PATTERN_INPUT_MASK_ADDR    = 8'h2d;

  // Reset values
  localparam logic [7:0] TOUCH_LIMIT_CONFIG_RST    = 8'h80;
  localparam logic [7:0] PATTERN_DETECT_CONFIG_RST = 8'h00;
  localparam logic [7:0] PATTERN_INPUT_MASK_RST    = 8'h07;

  // Writable bits; the rest read as zero
  localparam logic [7:0] TOUCH_LIMIT_CONFIG_WMASK    = 8'h8c;
  localparam logic [7:0] PATTERN_DETECT_CONFIG_WMASK = 8'h8f;
  localparam logic [7:0] PATTERN_INPUT_MASK_WMASK    = 8'h07;

  // Field positions
  localparam int TOUCH_BLOCK_ENABLE_BIT    = 7;
  localparam int LIMIT_FIELD_LSB           = 2;
  localparam int PATTERN_DETECT_ENABLE_BIT = 7;
  localparam int SCALE_FIELD_LSB           = 2;
  localparam int PATTERN_COMPARE_MODE_BIT  = 1;
  localparam int PATTERN_ALERT_ENABLE_BIT  = 0;

  // Pattern threshold scale codes
  localparam logic [1:0] SCALE_EIGHTH       = 2'h0;
  localparam logic [1:0] SCALE_QUARTER      = 2'h1;
  localparam logic [1:0] SCALE_THREE_EIGHTH = 2'h2;
  localparam logic [1:0] SCALE_FULL         = 2'h3;

  // Simultaneous touch limit codes
  localparam logic [1:0] LIMIT_ONE = 2'h0;
  localparam logic [1:0] LIMIT_TWO = 2'h1;

  localparam logic [2:0] ALL_INPUTS = 3'h7;
  localparam logic [2:0] NO_INPUTS  = 3'h0;

  typedef enum logic [0:0] {
    PAT_IDLE  = 1'b0,
    PAT_BLOCK = 1'b1
  } pat_state_t;

  // Number of set bits among the three inputs
  function automatic logic [1:0] count_set(input logic [2:0] v);
    logic [1:0] n;
    n = 2'h0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      n = n + {1'b0, v[i]};
    end
    return n;
  endfunction : count_set

  // Limit code to touch count
  function automatic logic [1:0] limit_of(input logic [1:0] code);
    logic [1:0] n;
    case (code)
      LIMIT_ONE: n = 2'h1;
      LIMIT_TWO: n = 2'h2;
      default:   n = 2'h3;
    endcase
    return n;
  endfunction : limit_of

endpackage : touch_block_pkg

// ==== hw/scale_compare.sv ====
// Per-input full-threshold and scaled pattern-threshold comparison
`timescale 1ns/1ps
module scale_compare
  import touch_block_pkg::*;
(
  input  wire logic [7:0] base_threshold, // Active or standby threshold
  input  wire logic [1:0] scale_code,     // Pattern threshold scale
  input  wire logic [7:0] delta_count,    // Measured delta
  input  wire logic       noise_flag,     // Noise status of this input
  output logic            full_hit,       // Above full threshold
  output logic            pattern_hit     // Above scaled threshold or noisy
);

  logic [7:0] scaled;

  always_comb begin
    case (scale_code)
      SCALE_EIGHTH:       scaled = base_threshold >> 3;
      SCALE_QUARTER:      scaled = base_threshold >> 2;
      SCALE_THREE_EIGHTH: scaled = (base_threshold >> 2)
                                   + (base_threshold >> 3);
      default:            scaled = base_threshold;
    endcase
    full_hit    = delta_count > base_threshold;
    pattern_hit = (delta_count > scaled) || noise_flag;
  end

endmodule : scale_compare

// ==== hw/touch_admit.sv ====
// Chooses which detected touches are reported under the touch limit
`timescale 1ns/1ps
module touch_admit
  import touch_block_pkg::*;
(
  input  wire logic       block_enable, // Blocking on
  input  wire logic [1:0] limit_code,   // Simultaneous touch limit field
  input  wire logic [2:0] admitted,     // Inputs reported last cycle
  input  wire logic [2:0] touched,      // Inputs above full threshold now
  output logic      [2:0] next_admit,   // Inputs to report this cycle
  output logic            excess        // More touches than the limit
);

  // First n set bits, input 1 first
  function automatic logic [2:0] first_n(input logic [2:0] v,
                                         input logic [1:0] n);
    logic [2:0] r;
    logic [1:0] k;
    r = NO_INPUTS;
    k = 2'h0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (v[i] && k < n) begin
        r[i] = 1'b1;
        k    = k + 2'h1;
      end
    end
    return r;
  endfunction : first_n

  logic [1:0] limit;
  logic       released;

  always_comb begin
    limit    = limit_of(limit_code);
    released = |(admitted & ~touched);
    excess   = block_enable && (count_set(touched) > limit);
    if (!block_enable) begin
      next_admit = touched;
    end else if (admitted != NO_INPUTS && !released) begin
      next_admit = admitted;
    end else begin
      next_admit = first_n(touched, limit);
    end
  end

endmodule : touch_admit

// ==== hw/touch_block_pattern.sv ====
// Touch limit blocking and multi-input pattern detection with registers
`timescale 1ns/1ps
module touch_block_pattern
  import touch_block_pkg::*;
(
  input  wire logic            clk,                  // 20 MHz system clock
  input  wire logic            reset,                // Sync reset, high
  input  wire logic [7:0]      reg_addr,             // Register offset
  input  wire logic [7:0]      reg_wdata,            // Write data
  input  wire logic            reg_write,            // Write strobe
  input  wire logic            reg_read,             // Read strobe
  input  wire logic            status_clear,         // Host clears INT bit
  input  wire logic            cycle_done,           // Polling results valid
  input  wire logic            standby_state,        // Device in standby
  input  wire logic [2:0][7:0] delta_count,          // Delta per input
  input  wire logic [2:0][7:0] touch_threshold,      // Threshold per input
  input  wire logic [7:0]      standby_threshold,    // Standby threshold
  input  wire logic [2:0]      noise_flag,           // Noise per input
  output logic      [7:0]      reg_rdata,            // Read data
  output logic      [2:0]      touch_report,         // Admitted touches
  output logic      [2:0]      input_blocked,        // Blocked inputs
  output logic                 excess_touch_status,  // Limit exceeded
  output logic                 pattern_event_status, // Pattern seen
  output logic                 pattern_active,       // Pattern holds now
  output logic                 alert_assert          // Alert request
);

  typedef struct packed {
    logic [7:0] touch_limit_config;
    logic [7:0] pattern_detect_config;
    logic [7:0] pattern_input_mask;
    logic [7:0] rdata;
    pat_state_t pat_state;
    logic       pat_status;
    logic       excess;
    logic       alert;
    logic [2:0] report;
    logic [2:0] blocked;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic       touch_block_enable;
  logic [1:0] simultaneous_touch_limit;
  logic       pattern_detect_enable;
  logic [1:0] pattern_threshold_scale;
  logic       pattern_compare_mode;
  logic       pattern_alert_enable;
  logic [2:0] mask;
  logic [2:0] full_hit;
  logic [2:0] pat_hit_in;
  logic [7:0] base_thr [NUM_INPUTS];
  logic [2:0] admit_next;
  logic       excess_now;
  logic       pattern_match;
  logic       pat_hit;

  assign touch_block_enable    = st.touch_limit_config[TOUCH_BLOCK_ENABLE_BIT];
  assign simultaneous_touch_limit =
    st.touch_limit_config[LIMIT_FIELD_LSB +: 2];
  assign pattern_detect_enable =
    st.pattern_detect_config[PATTERN_DETECT_ENABLE_BIT];
  assign pattern_threshold_scale =
    st.pattern_detect_config[SCALE_FIELD_LSB +: 2];
  assign pattern_compare_mode =
    st.pattern_detect_config[PATTERN_COMPARE_MODE_BIT];
  assign pattern_alert_enable =
    st.pattern_detect_config[PATTERN_ALERT_ENABLE_BIT];
  assign mask = st.pattern_input_mask[NUM_INPUTS-1:0];

  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_cmp
    assign base_thr[i] = standby_state ? standby_threshold
                                       : touch_threshold[i];
    scale_compare u_cmp (
      .base_threshold (base_thr[i]),
      .scale_code     (pattern_threshold_scale),
      .delta_count    (delta_count[i]),
      .noise_flag     (noise_flag[i]),
      .full_hit       (full_hit[i]),
      .pattern_hit    (pat_hit_in[i])
    );
  end

  touch_admit u_admit (
    .block_enable (touch_block_enable),
    .limit_code   (simultaneous_touch_limit),
    .admitted     (st.report),
    .touched      (full_hit),
    .next_admit   (admit_next),
    .excess       (excess_now)
  );

  // Pattern test on this polling cycle's results alone
  always_comb begin
    if (pattern_compare_mode) begin
      pattern_match = (pat_hit_in & mask) == mask;
    end else begin
      pattern_match = count_set(pat_hit_in) >= count_set(mask);
    end
    pat_hit = pattern_detect_enable && pattern_match;
  end

  always_comb begin
    next_st = st;
    // Register writes and reads
    if (reg_write) begin
      case (reg_addr)
        TOUCH_LIMIT_CONFIG_ADDR:
          next_st.touch_limit_config = reg_wdata & TOUCH_LIMIT_CONFIG_WMASK;
        PATTERN_DETECT_CONFIG_ADDR:
          next_st.pattern_detect_config =
            reg_wdata & PATTERN_DETECT_CONFIG_WMASK;
        PATTERN_INPUT_MASK_ADDR:
          next_st.pattern_input_mask = reg_wdata & PATTERN_INPUT_MASK_WMASK;
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        TOUCH_LIMIT_CONFIG_ADDR:    next_st.rdata = st.touch_limit_config;
        PATTERN_DETECT_CONFIG_ADDR: next_st.rdata = st.pattern_detect_config;
        PATTERN_INPUT_MASK_ADDR:    next_st.rdata = st.pattern_input_mask;
        default:                    next_st.rdata = 8'h00;
      endcase
    end
    // Host clear; a new event in the same cycle wins below
    if (status_clear) begin
      next_st.excess = 1'b0;
      next_st.alert  = 1'b0;
      if (st.pat_state == PAT_IDLE) begin
        next_st.pat_status = 1'b0;
      end
    end
    if (cycle_done) begin
      case (st.pat_state)
        PAT_IDLE: begin
          if (pat_hit) begin
            next_st.pat_state = PAT_BLOCK;
          end
        end
        PAT_BLOCK: begin
          if (!pat_hit) begin
            next_st.pat_state = PAT_IDLE;
          end
        end
        default: next_st.pat_state = PAT_IDLE;
      endcase
      if (pat_hit) begin
        next_st.pat_status = 1'b1;
        next_st.report     = NO_INPUTS;
        next_st.blocked    = ALL_INPUTS;
        if (pattern_alert_enable) begin
          next_st.alert = 1'b1;
        end
      end else begin
        next_st.report  = admit_next;
        next_st.blocked = full_hit & ~admit_next;
        if (excess_now) begin
          next_st.excess = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st.touch_limit_config    <= TOUCH_LIMIT_CONFIG_RST;
      st.pattern_detect_config <= PATTERN_DETECT_CONFIG_RST;
      st.pattern_input_mask    <= PATTERN_INPUT_MASK_RST;
      st.rdata                 <= 8'h00;
      st.pat_state             <= PAT_IDLE;
      st.pat_status            <= 1'b0;
      st.excess                <= 1'b0;
      st.alert                 <= 1'b0;
      st.report                <= NO_INPUTS;
      st.blocked               <= NO_INPUTS;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata            = st.rdata;
  assign touch_report         = st.report;
  assign input_blocked        = st.blocked;
  assign excess_touch_status  = st.excess;
  assign pattern_event_status = st.pat_status;
  assign pattern_active       = (st.pat_state == PAT_BLOCK);
  assign alert_assert         = st.alert;

  // Checks
  sequence pat_seen;
    cycle_done && pat_hit;
  endsequence

  sequence pat_gone;
    cycle_done && !pat_hit;
  endsequence

  // Polling cycle that goes through the limit logic
  sequence admit_cycle;
    cycle_done && touch_block_enable && !pat_hit;
  endsequence

  // Nothing held: a release, or nothing admitted yet
  sequence fresh_pick;
    (st.report & ~full_hit) != NO_INPUTS || st.report == NO_INPUTS;
  endsequence

  property p_no_block;
    @(posedge clk) disable iff (reset)
      cycle_done && !touch_block_enable && !pat_hit
      |=> input_blocked == NO_INPUTS && touch_report == $past(full_hit);
  endproperty

  property p_limit_cap;
    @(posedge clk) disable iff (reset)
      cycle_done && touch_block_enable
      |=> count_set(touch_report) <= $past(limit_of(simultaneous_touch_limit));
  endproperty

  property p_keep_admitted;
    @(posedge clk) disable iff (reset)
      cycle_done && touch_block_enable && !pat_hit
      && st.report != NO_INPUTS && (st.report & ~full_hit) == NO_INPUTS
      |=> touch_report == $past(touch_report);
  endproperty

  property p_excess_set;
    @(posedge clk) disable iff (reset)
      cycle_done && !pat_hit && touch_block_enable
      && count_set(full_hit) > limit_of(simultaneous_touch_limit)
      |=> excess_touch_status && input_blocked != NO_INPUTS;
  endproperty

  property p_pattern_block;
    @(posedge clk) disable iff (reset)
      pat_seen |=> input_blocked == ALL_INPUTS
                   && touch_report == NO_INPUTS
                   && pattern_event_status && pattern_active;
  endproperty

  property p_restore;
    @(posedge clk) disable iff (reset)
      pattern_active ##0 pat_gone |=> !pattern_active;
  endproperty

  property p_status_hold;
    @(posedge clk) disable iff (reset)
      pattern_event_status && pattern_active |=> pattern_event_status;
  endproperty

  property p_alert_gate;
    @(posedge clk) disable iff (reset)
      $rose(alert_assert)
      |-> $past(pattern_alert_enable && cycle_done && pat_hit);
  endproperty

  property p_disabled;
    @(posedge clk) disable iff (reset)
      !pattern_detect_enable && cycle_done |=> !pattern_active;
  endproperty

  property p_report_subset;
    @(posedge clk) disable iff (reset)
      cycle_done && !pat_hit
      |=> (touch_report & ~$past(full_hit)) == NO_INPUTS;
  endproperty

  property p_readmit_order;
    @(posedge clk) disable iff (reset)
      admit_cycle ##0 fresh_pick |=> touch_report[0] == $past(full_hit[0]);
  endproperty

  property p_alert_set;
    @(posedge clk) disable iff (reset)
      pat_seen ##0 pattern_alert_enable |=> alert_assert;
  endproperty

  property p_status_clear;
    @(posedge clk) disable iff (reset)
      status_clear && !pattern_active && !(cycle_done && pat_hit)
      |=> !pattern_event_status;
  endproperty

  property p_hold_between;
    @(posedge clk) disable iff (reset)
      !cycle_done |=> $stable(touch_report) && $stable(input_blocked)
                      && $stable(pattern_active);
  endproperty

  property p_blocked_active;
    @(posedge clk) disable iff (reset)
      pattern_active |-> touch_report == NO_INPUTS
                         && input_blocked == ALL_INPUTS;
  endproperty

  property p_excess_off;
    @(posedge clk) disable iff (reset)
      cycle_done && !touch_block_enable && !excess_touch_status
      |=> !excess_touch_status;
  endproperty

  no_block_a: assert property (p_no_block)
    else $error("touch blocked while blocking disabled");
  limit_cap_a: assert property (p_limit_cap)
    else $error("more touches reported than limit");
  keep_admitted_a: assert property (p_keep_admitted)
    else $error("admitted touches changed without release");
  excess_set_a: assert property (p_excess_set)
    else $error("excess touch status not set");
  pattern_block_a: assert property (p_pattern_block)
    else $error("pattern event did not block all inputs");
  pattern_restore_a: assert property (p_restore)
    else $error("blocking kept after pattern ended");
  status_hold_a: assert property (p_status_hold)
    else $error("pattern status lost during pattern");
  alert_gate_a: assert property (p_alert_gate)
    else $error("alert without enabled pattern event");
  pattern_disabled_a: assert property (p_disabled)
    else $error("pattern active while detector disabled");
  report_subset_a: assert property (p_report_subset)
    else $error("reported input not touched");
  readmit_order_a: assert property (p_readmit_order)
    else $error("first touched input not admitted");
  alert_set_a: assert property (p_alert_set)
    else $error("enabled pattern alert not raised");
  status_clear_a: assert property (p_status_clear)
    else $error("pattern status not cleared");
  hold_between_a: assert property (p_hold_between)
    else $error("outputs changed without polling cycle");
  blocked_active_a: assert property (p_blocked_active)
    else $error("touch reported during pattern");
  excess_off_a: assert property (p_excess_off)
    else $error("excess status set while blocking disabled");

endmodule : touch_block_pattern

// ==== dv/host_model.sv ====
// Host model issuing register and status-clear strobes
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,          // System clock
  input  wire logic [7:0] reg_rdata,    // Read data from block
  output logic      [7:0] reg_addr,     // Register offset
  output logic      [7:0] reg_wdata,    // Write data
  output logic            reg_write,    // Write strobe
  output logic            reg_read,     // Read strobe
  output logic            status_clear  // Status clear pulse
);
  initial begin
    reg_addr     = 8'h00;
    reg_wdata    = 8'h00;
    reg_write    = 1'b0;
    reg_read     = 1'b0;
    status_clear = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clk);
    #1;
    reg_write = 1'b0;
    // Released lines show the inverse, never the old value
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge clk);
    #1;
    reg_read = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask : rd

  task automatic clr();
    @(posedge clk);
    #1;
    status_clear = 1'b1;
    @(posedge clk);
    #1;
    status_clear = 1'b0;
  endtask : clr
endmodule : host_model

// ==== dv/test_multi_touch_block_pattern.sv ====
// Self-checking bench for touch blocking and pattern detection
`timescale 1ns/1ps
module test_multi_touch_block_pattern;
  import touch_block_pkg::*;
  logic            clk, reset, cycle_done, standby_state;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata, standby_threshold, rv;
  logic            reg_write, reg_read, status_clear;
  logic [2:0][7:0] delta_count, touch_threshold;
  logic [2:0]      noise_flag, touch_report, input_blocked, t, m;
  logic            excess_touch_status, pattern_event_status;
  logic            pattern_active, alert_assert, md, en, al, ex;
  logic [1:0]      sc;
  int              fail_count, checks, cyc, lim;
  logic [7:0]      adr [3] = '{8'h2a, 8'h2b, 8'h2d};
  logic [7:0]      rst [3] = '{8'h80, 8'h00, 8'h07};
  logic [7:0]      wm  [3] = '{8'h8c, 8'h8f, 8'h07};

  touch_block_pattern dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .status_clear(status_clear), .cycle_done(cycle_done),
    .standby_state(standby_state), .delta_count(delta_count),
    .touch_threshold(touch_threshold),
    .standby_threshold(standby_threshold), .noise_flag(noise_flag),
    .reg_rdata(reg_rdata), .touch_report(touch_report),
    .input_blocked(input_blocked),
    .excess_touch_status(excess_touch_status),
    .pattern_event_status(pattern_event_status),
    .pattern_active(pattern_active), .alert_assert(alert_assert));

  host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .status_clear(status_clear));

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk1(input logic g, input logic e, input string s);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t %s got %b exp %b", $time, s, g, e);
    end
  endtask : chk1

  task automatic chk3(input logic [2:0] g, input logic [2:0] e,
                      input string s);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t %s got %b exp %b", $time, s, g, e);
    end
  endtask : chk3

  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                      input string s);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk8

  function automatic logic [7:0] scaled(logic [7:0] v, logic [1:0] s);
    case (s)
      2'h0:    return v >> 3;
      2'h1:    return v >> 2;
      2'h2:    return (v >> 2) + (v >> 3);
      default: return v;
    endcase
  endfunction : scaled

  function automatic int ones(logic [2:0] v);
    return int'(v[0]) + int'(v[1]) + int'(v[2]);
  endfunction : ones

  function automatic logic [2:0] first_n(logic [2:0] v, int n);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (v[i] && n > 0) begin
        r[i] = 1'b1;
        n--;
      end
    end
    return r;
  endfunction : first_n

  function automatic logic pat_exp();
    logic [2:0] h;
    logic [7:0] b;
    for (int i = 0; i < 3; i++) begin
      b = standby_state ? standby_threshold : touch_threshold[i];
      h[i] = noise_flag[i] || (delta_count[i] > scaled(b, sc));
    end
    return md ? ((h & m) == m) : (ones(h) >= ones(m));
  endfunction : pat_exp

  task automatic poll();
    @(posedge clk);
    #1;
    cycle_done = 1'b1;
    @(posedge clk);
    #1;
    cycle_done = 1'b0;
  endtask : poll

  task automatic touch(input logic [2:0] v);
    for (int i = 0; i < 3; i++) begin
      delta_count[i]     = v[i] ? 8'hc8 : 8'h00;
      touch_threshold[i] = 8'h64;
    end
    noise_flag = 3'h0;
    poll();
  endtask : touch

  initial begin
    clk = 0; reset = 1; cycle_done = 0; standby_state = 0;
    standby_threshold = 8'h40; delta_count = '0; touch_threshold = '0;
    noise_flag = 3'h0;
    repeat (6) @(posedge clk);
    #1;
    reset = 0;
    void'($urandom(32'h83cf_3b54));
    chk3(touch_report | input_blocked, 3'h0, "idle out");
    chk1(pattern_event_status | pattern_active, 1'b0, "idle");
    for (int i = 0; i < 3; i++) begin
      host.rd(adr[i], rv);
      chk8(rv, rst[i], "reset value");
      host.wr(adr[i], 8'hff);
      host.rd(adr[i], rv);
      chk8(rv, wm[i], "write mask");
      host.wr(adr[i], rst[i]);
    end
    host.wr(8'h2c, 8'hff);
    host.rd(8'h2c, rv);
    chk8(rv, 8'h00, "unmapped");
    $display("test registers done");
    for (int c = 0; c < 5; c++) begin
      // Code 4 stands for blocking disabled
      host.wr(8'h2a, c == 4 ? 8'h0c : 8'h80 | 8'(c << 2));
      lim = c == 4 ? 3 : (c == 0 ? 1 : (c == 1 ? 2 : 3));
      touch(3'h0);
      host.clr();
      touch(3'h7);
      chk3(touch_report, first_n(3'h7, lim), "report");
      chk3(input_blocked, ~first_n(3'h7, lim), "blocked");
      chk1(excess_touch_status, lim < 3, "excess");
    end
    host.wr(8'h2a, 8'h80);
    touch(3'h0);
    touch(3'h3);
    touch(3'h7);
    chk3(touch_report, 3'h1, "hold");
    touch(3'h6);
    chk3(touch_report, 3'h2, "readmit");
    chk3(input_blocked, 3'h4, "readmit blk");
    $display("test blocking done");
    for (int k = 0; k < 60; k++) begin
      md = 1'($urandom); sc = 2'($urandom); al = 1'($urandom);
      m = 3'(1 + $urandom % 7); en = ($urandom % 4) != 0;
      host.wr(8'h2b, {en, 3'h0, sc, md, al});
      host.wr(8'h2d, {5'h0, m});
      touch(3'h0);
      host.clr();
      chk1(pattern_event_status, 1'b0, "cleared");
      standby_state = 1'($urandom);
      standby_threshold = 8'($urandom);
      for (int i = 0; i < 3; i++) begin
        touch_threshold[i] = 8'($urandom);
        delta_count[i] = 8'($urandom);
      end
      noise_flag = 3'($urandom) & 3'($urandom);
      ex = en && pat_exp();
      poll();
      chk1(pattern_active, ex, "active");
      chk1(pattern_event_status, ex, "status");
      chk1(alert_assert, ex && al, "alert");
      if (ex) begin
        chk3(input_blocked, 3'h7, "all blk");
        chk3(touch_report, 3'h0, "no report");
        host.clr();
        chk1(pattern_event_status, 1'b1, "held");
        // One strong touch on input 1; pattern may still hold
        standby_state = 1'b0;
        touch(3'h1);
        ex = pat_exp();
        chk1(pattern_active, ex, "ended");
        chk3(input_blocked, {3{ex}}, "restored");
        chk3(touch_report, {2'h0, !ex}, "restored rpt");
      end
    end
    $display("test pattern done");
    close_out();
  end
endmodule : test_multi_touch_block_pattern
